//--- hw/a4tx_top.sv
// serial word transmitter with fifo, parity, loopback, repeater and two receivers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - low half then high half forms word
// - eight-word fifo, high-half loads ignored when full
// - empty flag high once all sent
// - go starts oldest word promptly
// - cell 10 or 80 clocks, gap four cells
// - data half then null half
// - override pin or insert bit selects parity
// - parity odd when sense low, even high
// - loopback when bit low, rx2 complemented
// - outputs stay active during loopback
// - newer received word overwrites unread word
// - flag clears after both halves read
// - master clear empties fifo and flags
// - master clear keeps control register
// - full 32 bits sets word-ready flag
// - repeat low half into fifo
// - repeat high half completes fifo word
// - repeated word uses current parity settings
// - data clock divides by 10 or 80
module a4tx_top #(
    parameter int FIFO_DEPTH = a4tx_pkg::FIFO_WORDS,
    parameter logic [a4tx_pkg::CNT_W-1:0] CELL_FAST = 9'(a4tx_pkg::CELL_CLKS_FAST),
    parameter logic [a4tx_pkg::CNT_W-1:0] CELL_SLOW = 9'(a4tx_pkg::CELL_CLKS_SLOW)
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [a4tx_pkg::ADDR_W-1:0] PADDR,
    input wire logic [a4tx_pkg::DATA_W-1:0] PWDATA,
    output logic [a4tx_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TRANSMIT_GO,
    input wire logic PARITY_OVERRIDE_PIN,
    input wire logic MASTER_CLEAR,
    input wire logic RX1_LINE_TRUE,
    input wire logic RX1_LINE_COMP,
    input wire logic RX2_LINE_TRUE,
    input wire logic RX2_LINE_COMP,
    output logic SERIAL_OUT_TRUE,
    output logic SERIAL_OUT_COMP,
    output logic TX_EMPTY,
    output logic RX1_READY_B,
    output logic RX2_READY_B
);
    import a4tx_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(FIFO_DEPTH);
    localparam logic [4:0] LAST_BIT = 5'(WORD_BITS - 1);

    // bus half-word to word packing, index 0 is first bit on the line
    function automatic logic [31:0] pack_word(input logic [15:0] lo, input logic [15:0] hi);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int k = 0; k < 8; k++) begin
            w[k] = lo[7-k];
        end
        w[31] = lo[8];
        w[29] = lo[9];
        w[30] = lo[10];
        w[12:8] = lo[15:11];
        w[28:13] = hi;
        return w;
    endfunction

    function automatic logic [15:0] half_lo(input logic [31:0] w);
        logic [15:0] lo;
        lo = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            lo[7-k] = w[k];
        end
        lo[8] = w[31];
        lo[9] = w[29];
        lo[10] = w[30];
        lo[15:11] = w[12:8];
        return lo;
    endfunction

    function automatic logic [CNT_W-1:0] cell_len(input logic slow);
        return slow ? CELL_SLOW : CELL_FAST;
    endfunction

    function automatic logic [31:0] rx_half(input logic [31:0] w, input logic hi);
        return hi ? {16'h0000, w[28:13]} : {16'h0000, half_lo(w)};
    endfunction

    logic [CTRL_W-1:0] ctrl_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [15:0] lo_hold_q;
    logic [31:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] cnt_q;
    a4tx_state_e state_q;
    logic [CNT_W-1:0] cyc_q;
    logic [4:0] bit_q;
    logic [31:0] shift_q;
    logic out_t_q;
    logic out_c_q;
    logic tx_empty_q;
    logic [1:0] rdy_b_q;
    logic [1:0] got_lo_q;
    logic [1:0] got_hi_q;
    logic [1:0] act_q;
    logic [31:0] rx_sh_q [2];
    logic [5:0] rx_cnt_q [2];
    logic [CNT_W-1:0] rx_idle_q [2];
    logic [31:0] rx_word_q [2];

    logic access_done;
    logic wr_en;
    logic rd_en;
    logic rep_en;
    logic rep_rx;
    logic rep_half;
    logic lo_load;
    logic hi_load;
    logic [15:0] lo_data;
    logic [15:0] hi_data;
    logic [15:0] rep_val;
    logic [31:0] rep_word;
    logic [1:0] rd_lo;
    logic [1:0] rd_hi;
    logic fifo_full;
    logic push;
    logic pop;
    logic [31:0] head_word;
    logic par_bit;
    logic par_used;
    logic [CNT_W-1:0] tx_cell;
    logic [CNT_W-1:0] tx_half;
    logic [CNT_W-1:0] tx_gap;
    logic [CNT_W-1:0] rx_limit;
    logic [1:0] in_t;
    logic [1:0] in_c;
    logic loop_on;
    logic busy;

    assign access_done = PSEL & PENABLE & pready_q;
    assign wr_en = access_done & PWRITE;
    assign rd_en = access_done & ~PWRITE;
    assign rep_en = wr_en && (PADDR == OFF_REPEAT);
    assign rep_rx = PWDATA[REP_RX_SEL];
    assign rep_half = PWDATA[REP_HALF_SEL];
    assign rep_word = rx_half(rx_word_q[rep_rx], rep_half);
    assign rep_val = rep_word[15:0];

    // repeat with low half acts as low load
    assign lo_load = (wr_en && (PADDR == OFF_TX_LO)) || (rep_en && !rep_half);
    // repeat with high half completes the word
    assign hi_load = (wr_en && (PADDR == OFF_TX_HI)) || (rep_en && rep_half);
    assign lo_data = rep_en ? rep_val : PWDATA[15:0];
    assign hi_data = rep_en ? rep_val : PWDATA[15:0];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            rd_lo[i] = (rd_en && (PADDR == (i == 0 ? OFF_RX1_LO : OFF_RX2_LO)))
                || (rep_en && (rep_rx == i[0]) && !rep_half);
            rd_hi[i] = (rd_en && (PADDR == (i == 0 ? OFF_RX1_HI : OFF_RX2_HI)))
                || (rep_en && (rep_rx == i[0]) && rep_half);
        end
    end

    // register bus: no wait states, answer in first access cycle
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (CE) begin
            pready_q <= PSEL & ~PENABLE;
            pslverr_q <= 1'b0;
            if (PSEL & ~PENABLE) begin
                prdata_q <= 32'h0000_0000;
                unique case (PADDR)
                    OFF_CTRL: prdata_q <= {{(32 - CTRL_W){1'b0}}, ctrl_q};
                    OFF_STATUS: begin
                        prdata_q[ST_TX_EMPTY] <= tx_empty_q;
                        prdata_q[ST_RX1_AVAIL] <= ~rdy_b_q[0];
                        prdata_q[ST_RX2_AVAIL] <= ~rdy_b_q[1];
                        prdata_q[ST_TX_BUSY] <= busy;
                        prdata_q[ST_COUNT_LSB +: PTR_W + 1] <= cnt_q;
                    end
                    OFF_RX1_LO: prdata_q <= rx_half(rx_word_q[0], 1'b0);
                    OFF_RX1_HI: prdata_q <= rx_half(rx_word_q[0], 1'b1);
                    OFF_RX2_LO: prdata_q <= rx_half(rx_word_q[1], 1'b0);
                    OFF_RX2_HI: prdata_q <= rx_half(rx_word_q[1], 1'b1);
                    OFF_TX_LO, OFF_TX_HI, OFF_REPEAT: prdata_q <= 32'h0000_0000;
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // control register untouched by master clear
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= CTRL_RESET;
        end else if (CE && wr_en && (PADDR == OFF_CTRL)) begin
            ctrl_q <= PWDATA[CTRL_W-1:0];
        end
    end

    // low half held until high half arrives
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            lo_hold_q <= 16'h0000;
        end else if (CE) begin
            if (MASTER_CLEAR) begin
                lo_hold_q <= 16'h0000;
            end else if (lo_load) begin
                lo_hold_q <= lo_data;
            end
        end
    end

    assign fifo_full = (cnt_q == FULL_CNT);
    assign push = hi_load && !fifo_full && !MASTER_CLEAR;
    assign head_word = fifo_mem[rd_ptr_q];

    always_ff @(posedge MCLK) begin
        if (CE && push) begin
            fifo_mem[wr_ptr_q] <= pack_word(lo_hold_q, hi_data);
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else if (CE) begin
            if (MASTER_CLEAR) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
                cnt_q <= '0;
            end else begin
                if (push) begin
                    wr_ptr_q <= wr_ptr_q + 1'b1;
                end
                if (pop) begin
                    rd_ptr_q <= rd_ptr_q + 1'b1;
                end
                if (push && !pop) begin
                    cnt_q <= cnt_q + 1'b1;
                end else if (pop && !push) begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    // odd parity with sense low, even with sense high
    assign par_bit = ~(^head_word[30:0]) ^ ctrl_q[CTRL_PAR_SENSE];
    // pin high forces parity, else insert bit decides
    // settings sampled when the word leaves the fifo
    assign par_used = PARITY_OVERRIDE_PIN | ctrl_q[CTRL_PAR_INS];

    assign tx_cell = cell_len(ctrl_q[CTRL_TX_CLK]);
    assign tx_half = tx_cell >> 1;
    assign tx_gap = CNT_W'(tx_cell * GAP_CELLS);
    assign busy = (state_q == TX_DATA) || (state_q == TX_NULL);

    always_comb begin
        pop = 1'b0;
        if (TRANSMIT_GO && (cnt_q != '0) && !MASTER_CLEAR) begin
            pop = (state_q == TX_IDLE) || ((state_q == TX_GAP) && (cyc_q == tx_gap - 1'b1));
        end
    end

    // go high with a queued word starts at the next edge, or when a running gap ends
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= TX_IDLE;
            cyc_q <= '0;
            bit_q <= '0;
            shift_q <= 32'h0000_0000;
            out_t_q <= 1'b0;
            out_c_q <= 1'b0;
        end else if (CE) begin
            cyc_q <= cyc_q + 1'b1;
            if (MASTER_CLEAR || (!TRANSMIT_GO && busy)) begin
                // go dropped early loses the word in flight
                state_q <= TX_IDLE;
                out_t_q <= 1'b0;
                out_c_q <= 1'b0;
            end else if (pop) begin
                state_q <= TX_DATA;
                cyc_q <= '0;
                bit_q <= '0;
                shift_q <= {par_used ? par_bit : head_word[31], head_word[30:0]};
                // true for one, complement for zero
                out_t_q <= head_word[0];
                out_c_q <= ~head_word[0];
            end else begin
                unique case (state_q)
                    TX_IDLE: cyc_q <= '0;
                    TX_DATA: begin
                        if (cyc_q == tx_half - 1'b1) begin
                            state_q <= TX_NULL;
                            cyc_q <= '0;
                            out_t_q <= 1'b0;
                            out_c_q <= 1'b0;
                        end
                    end
                    TX_NULL: begin
                        if (cyc_q == tx_half - 1'b1) begin
                            cyc_q <= '0;
                            if (bit_q == LAST_BIT) begin
                                state_q <= TX_GAP;
                            end else begin
                                state_q <= TX_DATA;
                                bit_q <= bit_q + 1'b1;
                                shift_q <= {1'b0, shift_q[31:1]};
                                out_t_q <= shift_q[1];
                                out_c_q <= ~shift_q[1];
                            end
                        end
                    end
                    TX_GAP: begin
                        if (cyc_q == tx_gap - 1'b1) begin
                            state_q <= TX_IDLE;
                            cyc_q <= '0;
                        end
                    end
                endcase
            end
        end
    end

    // empty once fifo drained and no word on the line
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_empty_q <= 1'b1;
        end else if (CE) begin
            tx_empty_q <= MASTER_CLEAR || ((cnt_q == '0) && !push && !pop && !busy);
        end
    end

    // loopback feeds rx1 true stream, rx2 complement
    // line outputs keep running while looped back
    assign loop_on = ~ctrl_q[CTRL_LOOP_N];
    assign in_t[0] = loop_on ? out_t_q : RX1_LINE_TRUE;
    assign in_c[0] = loop_on ? out_c_q : RX1_LINE_COMP;
    assign in_t[1] = loop_on ? out_c_q : RX2_LINE_TRUE;
    assign in_c[1] = loop_on ? out_t_q : RX2_LINE_COMP;
    assign rx_limit = CNT_W'(cell_len(ctrl_q[CTRL_RX_CLK]) * RX_IDLE_CELLS);

    // receivers: a bit on each null-to-data step, long null resets the word
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            act_q <= 2'b00;
            rdy_b_q <= 2'b11;
            got_lo_q <= 2'b00;
            got_hi_q <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                rx_sh_q[i] <= 32'h0000_0000;
                rx_cnt_q[i] <= '0;
                rx_idle_q[i] <= '0;
                rx_word_q[i] <= 32'h0000_0000;
            end
        end else if (CE) begin
            for (int i = 0; i < 2; i++) begin
                if (MASTER_CLEAR) begin
                    act_q[i] <= 1'b0;
                    rdy_b_q[i] <= 1'b1;
                    got_lo_q[i] <= 1'b0;
                    got_hi_q[i] <= 1'b0;
                    rx_cnt_q[i] <= '0;
                    rx_idle_q[i] <= '0;
                    rx_word_q[i] <= 32'h0000_0000;
                end else begin
                    act_q[i] <= in_t[i] | in_c[i];
                    // both halves read clears the flag
                    if (rd_lo[i]) begin
                        got_lo_q[i] <= 1'b1;
                    end
                    if (rd_hi[i]) begin
                        got_hi_q[i] <= 1'b1;
                    end
                    if ((got_lo_q[i] | rd_lo[i]) && (got_hi_q[i] | rd_hi[i])) begin
                        rdy_b_q[i] <= 1'b1;
                        got_lo_q[i] <= 1'b0;
                        got_hi_q[i] <= 1'b0;
                    end
                    if (in_t[i] | in_c[i]) begin
                        rx_idle_q[i] <= '0;
                    end else if (rx_idle_q[i] != rx_limit) begin
                        rx_idle_q[i] <= rx_idle_q[i] + 1'b1;
                    end else begin
                        rx_cnt_q[i] <= '0;
                    end
                    if ((in_t[i] | in_c[i]) && !act_q[i]) begin
                        rx_sh_q[i] <= {in_t[i], rx_sh_q[i][31:1]};
                        if (rx_cnt_q[i] == 6'(WORD_BITS - 1)) begin
                            rx_cnt_q[i] <= '0;
                            // new word overwrites, set wins over clear
                            rx_word_q[i] <= {~(^{in_t[i], rx_sh_q[i][31:1]}), rx_sh_q[i][31:1]};
                            rdy_b_q[i] <= 1'b0;
                            got_lo_q[i] <= 1'b0;
                            got_hi_q[i] <= 1'b0;
                        end else begin
                            rx_cnt_q[i] <= rx_cnt_q[i] + 1'b1;
                        end
                    end
                end
            end
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign SERIAL_OUT_TRUE = out_t_q;
    assign SERIAL_OUT_COMP = out_c_q;
    assign TX_EMPTY = tx_empty_q;
    assign RX1_READY_B = rdy_b_q[0];
    assign RX2_READY_B = rdy_b_q[1];
endmodule

`default_nettype wire

//--- hw/a4tx_pkg.sv
// constants and types for the serial word transmitter with dual receivers
package a4tx_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TX_LO = 8'h04;
    localparam logic [7:0] OFF_TX_HI = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_RX1_LO = 8'h10;
    localparam logic [7:0] OFF_RX1_HI = 8'h14;
    localparam logic [7:0] OFF_RX2_LO = 8'h18;
    localparam logic [7:0] OFF_RX2_HI = 8'h1C;
    localparam logic [7:0] OFF_REPEAT = 8'h20;

    // control register fields
    localparam int CTRL_W = 5;
    localparam int CTRL_PAR_INS = 0;
    localparam int CTRL_LOOP_N = 1;
    localparam int CTRL_PAR_SENSE = 2;
    localparam int CTRL_TX_CLK = 3;
    localparam int CTRL_RX_CLK = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h02;

    // status register fields
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_RX1_AVAIL = 1;
    localparam int ST_RX2_AVAIL = 2;
    localparam int ST_TX_BUSY = 3;
    localparam int ST_COUNT_LSB = 4;

    // repeat register fields
    localparam int REP_RX_SEL = 0;
    localparam int REP_HALF_SEL = 1;

    // timing in master clocks
    localparam int CNT_W = 9;
    localparam int CELL_CLKS_FAST = 10;
    localparam int CELL_CLKS_SLOW = 80;
    localparam int GAP_CELLS = 4;
    localparam int RX_IDLE_CELLS = 2;
    localparam int WORD_BITS = 32;
    localparam int FIFO_WORDS = 8;

    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_NULL, TX_GAP} a4tx_state_e;
endpackage

//--- tb/a4tx_props.sv
// concurrent checks on the transmitter ports
`timescale 1ns/1ps
`default_nettype none
module a4tx_props #(
    parameter logic [a4tx_pkg::CNT_W-1:0] CELL_FAST = 9'(a4tx_pkg::CELL_CLKS_FAST),
    parameter logic [a4tx_pkg::CNT_W-1:0] CELL_SLOW = 9'(a4tx_pkg::CELL_CLKS_SLOW)
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [a4tx_pkg::ADDR_W-1:0] PADDR,
    input wire logic [a4tx_pkg::DATA_W-1:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic TRANSMIT_GO,
    input wire logic MASTER_CLEAR,
    input wire logic SERIAL_OUT_TRUE,
    input wire logic SERIAL_OUT_COMP,
    input wire logic TX_EMPTY
);
    import a4tx_pkg::*;
    logic slow_q;
    logic act;
    logic [15:0] run_q;
    logic [15:0] idle_q;
    int half;
    assign act = SERIAL_OUT_TRUE | SERIAL_OUT_COMP;
    assign half = slow_q ? int'(CELL_SLOW) / 2 : int'(CELL_FAST) / 2;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // follows the transmit clock select
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            slow_q <= CTRL_RESET[CTRL_TX_CLK];
        end else if (CE && PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_CTRL) begin
            slow_q <= PWDATA[CTRL_TX_CLK];
        end
    end
    // lengths of active and null runs
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            run_q <= 16'h0000;
            idle_q <= 16'hFFFF;
        end else if (CE) begin
            run_q <= act ? run_q + 16'h0001 : 16'h0000;
            idle_q <= act ? 16'h0000 : idle_q + 16'(idle_q != 16'hFFFF);
        end
    end
    sequence s_setup;
        PSEL && !PENABLE && CE;
    endsequence
    sequence s_go;
        !TRANSMIT_GO ##1 TRANSMIT_GO && !TX_EMPTY && idle_q > 8 * half;
    endsequence
    a_ready_after_setup: assert property (s_setup ##1 PENABLE |-> PREADY)
        else $error("no ready in first access cycle");
    a_err_unmapped: assert property (PSEL && PENABLE && PREADY && PADDR > OFF_REPEAT |-> PSLVERR)
        else $error("unmapped access without error");
    a_clear_empties: assert property (MASTER_CLEAR && CE |=> TX_EMPTY && !act)
        else $error("master clear left transmitter busy");
    a_outs_exclusive: assert property (!(SERIAL_OUT_TRUE && SERIAL_OUT_COMP))
        else $error("both serial outputs high");
    a_data_half: assert property ($fell(act) && !$past(MASTER_CLEAR) |-> run_q == half)
        else $error("data half of wrong length");
    a_null_half: assert property ($rose(act) |-> idle_q == half || idle_q > 6 * half)
        else $error("null half or gap of wrong length");
    a_busy_not_empty: assert property (act |-> !TX_EMPTY)
        else $error("empty flag high while sending");
    a_go_starts: assert property (s_go |-> ##[1:25] act)
        else $error("first bit late after go");
endmodule
bind a4tx_top a4tx_props #(.CELL_FAST(CELL_FAST), .CELL_SLOW(CELL_SLOW)) u_props (
    .MCLK(MCLK), .RST_B(RST_B), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TRANSMIT_GO(TRANSMIT_GO), .MASTER_CLEAR(MASTER_CLEAR), .TX_EMPTY(TX_EMPTY),
    .SERIAL_OUT_TRUE(SERIAL_OUT_TRUE), .SERIAL_OUT_COMP(SERIAL_OUT_COMP));
`default_nettype wire

//--- tb/a4tx_line_model.sv
// line side: echoes the transmit line and decodes whole words
`timescale 1ns/1ps
`default_nettype none
module a4tx_line_model #(
    parameter int GAP_IDLE = 42
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_true,
    input wire logic tx_comp,
    output logic line_true,
    output logic line_comp,
    output logic [31:0] word_q,
    output logic [7:0] word_cnt
);
    logic act;
    logic act_q;
    logic [4:0] bit_q;
    logic [9:0] idle_q;
    assign act = tx_true | tx_comp;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {line_true, line_comp} <= 2'h0;
        end else begin
            {line_true, line_comp} <= {tx_true, tx_comp};
        end
    end
    // bit at data start, long null ends word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {act_q, bit_q, idle_q, word_q, word_cnt} <= '0;
        end else begin
            act_q <= act;
            idle_q <= act ? 10'h000 : idle_q + 10'(idle_q != 10'h3FF);
            if (idle_q > 10'(GAP_IDLE)) bit_q <= 5'h00;
            if (act && !act_q) begin
                word_q[bit_q] <= tx_true;
                bit_q <= bit_q + 5'h01;
                if (bit_q == 5'h1F) word_cnt <= word_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/a4tx_top_tb.sv
// self-checking bench for the serial word transmitter
`timescale 1ns/1ps
`default_nettype none
module a4tx_top_tb;
    import a4tx_pkg::*;
    typedef struct packed {logic [4:0] c; logic ovr; logic [15:0] lo; logic [15:0] hi;} a4tx_row_s;
    logic mclk, rst_b, psel, penable, pwrite, go, ovr, mclr, er;
    logic sot, soc, lt, lc, tx_empty, rx1_rdy_b, rx2_rdy_b, pready, pslverr;
    logic [7:0] paddr;
    logic [7:0] wcnt;
    logic [31:0] pwdata, prdata, rd, word;
    int bad_count, n_checks, i;
    a4tx_row_s rows [6] = '{'{5'h02, 1'b1, 16'hA5C3, 16'h1234}, '{5'h1B, 1'b0, 16'h3C5A, 16'h0F0F},
        '{5'h02, 1'b0, 16'h0100, 16'h0},
        '{5'h03, 1'b0, 16'h7E81, 16'hFFFF}, '{5'h07, 1'b0, 16'h00FF, 16'h8001},
        '{5'h06, 1'b1, 16'hFEFF, 16'h0}};
    a4tx_top u_a4tx_top (.MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TRANSMIT_GO(go), .PARITY_OVERRIDE_PIN(ovr), .MASTER_CLEAR(mclr),
        .RX1_LINE_TRUE(lt), .RX1_LINE_COMP(lc), .RX2_LINE_TRUE(lt), .RX2_LINE_COMP(lc),
        .SERIAL_OUT_TRUE(sot), .SERIAL_OUT_COMP(soc), .TX_EMPTY(tx_empty),
        .RX1_READY_B(rx1_rdy_b), .RX2_READY_B(rx2_rdy_b));
    a4tx_line_model u_line (.clk(mclk), .rst_b(rst_b), .tx_true(sot), .tx_comp(soc),
        .line_true(lt), .line_comp(lc), .word_q(word), .word_cnt(wcnt));
    always #25 mclk = ~mclk;
    // line order of the word, bit 32 from data or parity
    function automatic logic [31:0] exp_word(logic [4:0] c, logic o, logic [15:0] lo, hi);
        logic [31:0] w;
        w = '0;
        for (int k = 1; k <= 8; k++) w[k-1] = lo[8-k];
        for (int k = 9; k <= 13; k++) w[k-1] = lo[k+2];
        for (int k = 14; k <= 29; k++) w[k-1] = hi[k-14];
        w[29] = lo[9];
        w[30] = lo[10];
        w[31] = (o || c[CTRL_PAR_INS]) ? ^w[30:0] ^ ~c[CTRL_PAR_SENSE] : lo[8];
        return w;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, ref logic g);
        @(posedge mclk);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic load(input logic [15:0] lo, input logic [15:0] hi);
        apb(1'b1, OFF_TX_LO, {16'h0, lo});
        apb(1'b1, OFF_TX_HI, {16'h0, hi});
    endtask
    task automatic wait_word(input logic [31:0] e);
        logic [7:0] c;
        c = wcnt;
        while (wcnt === c) @(posedge mclk);
        chk("line word", e, word);
    endtask
    task automatic drop_go;
        while (tx_empty !== 1'b1) @(posedge mclk);
        go <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        print_verdict;
    end
    initial begin
        {mclk, rst_b, psel, penable, pwrite, go, mclr} = '0;
        ovr = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        chkb("tx empty", 1'b1, tx_empty);
        chkb("rx1 ready", 1'b1, rx1_rdy_b);
        rdchk("ctrl", OFF_CTRL, 32'h00000002);
        rdchk("status", OFF_STATUS, 32'h00000001);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        for (i = 0; i < 6; i++) begin
            apb(1'b1, OFF_CTRL, {27'h0, rows[i].c});
            ovr <= rows[i].ovr;
            load(rows[i].lo, rows[i].hi);
            go <= 1'b1;
            wait_word(exp_word(rows[i].c, rows[i].ovr, rows[i].lo, rows[i].hi));
            drop_go;
            // let the word gap run out before the next mode
            repeat (400) @(posedge mclk);
        end
        load(16'h1111, 16'h2222);
        load(16'h3333, 16'h4444);
        go <= 1'b1;
        wait_word(exp_word(5'h06, 1'b1, 16'h1111, 16'h2222));
        wait_word(exp_word(5'h06, 1'b1, 16'h3333, 16'h4444));
        drop_go;
        rdchk("rx1 lo", OFF_RX1_LO, 32'h00003333);
        rdchk("rx1 hi", OFF_RX1_HI, 32'h00004444);
        chkb("rx1 ready", 1'b1, rx1_rdy_b);
        apb(1'b1, OFF_CTRL, 32'h00000000);
        load(16'h5A0F, 16'hC3A5);
        go <= 1'b1;
        wait_word(exp_word(5'h00, 1'b1, 16'h5A0F, 16'hC3A5));
        drop_go;
        chkb("rx1 ready", 1'b0, rx1_rdy_b);
        rdchk("rx2 lo", OFF_RX2_LO, {16'h0, ~16'h5A0F & 16'hFEFF});
        rdchk("rx2 hi", OFF_RX2_HI, {16'h0, ~16'hC3A5});
        chkb("rx2 ready", 1'b1, rx2_rdy_b);
        rdchk("rx1 hi", OFF_RX1_HI, 32'h0000C3A5);
        chkb("rx1 ready", 1'b0, rx1_rdy_b);
        apb(1'b1, OFF_REPEAT, 32'h0);
        apb(1'b1, OFF_REPEAT, 32'h2);
        chkb("rx1 ready", 1'b1, rx1_rdy_b);
        apb(1'b1, OFF_CTRL, 32'h00000007);
        ovr <= 1'b0;
        go <= 1'b1;
        wait_word(exp_word(5'h07, 1'b0, 16'h5A0F, 16'hC3A5));
        drop_go;
        for (i = 0; i < 9; i++) load(16'(i), 16'h0);
        rdchk("status full", OFF_STATUS, 32'h00000086);
        mclr <= 1'b1;
        @(posedge mclk);
        mclr <= 1'b0;
        chkb("rx1 ready", 1'b1, rx1_rdy_b);
        rdchk("status clear", OFF_STATUS, 32'h00000001);
        rdchk("ctrl kept", OFF_CTRL, 32'h00000007);
        print_verdict;
    end
endmodule
`default_nettype wire
